// ---- design/mode_irq_consts.svh ----
// Constants for the mode select and interrupt request pin block.
`ifndef MODE_IRQ_CONSTS_SVH
`define MODE_IRQ_CONSTS_SVH
`define MODE_PIN_COUNT    4
`define IRQ_PIN_COUNT     3
`define SYNC_STAGES       2
`define OMR_RESET_VALUE   4'h0
`define WAKE_PIN_INDEX    0
`endif

// ---- design/mode_irq_pkg.sv ----
// Types shared by the mode select and interrupt request pin block.
package mode_irq_pkg;
	typedef enum logic [1:0] {
		PORT_DISCONNECTED,
		PORT_INPUT,
		PORT_OUTPUT,
		PORT_RESERVED
	} port_dir_type;

	typedef struct packed {
		logic enable;
		logic edgeMode;
		logic ack;
	} irq_ctrl_type;

	typedef enum {
		PHASE_RESET,
		PHASE_RUN
	} phase_type;
endpackage

// ---- design/pin_sync.sv ----
// Two-flop synchroniser for one input pin.
`timescale 1ns/1ns
module pin_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin and synchronised level
	input  wire logic pinIn,
	output logic      pinSync
);
	logic [STAGES-1:0] chain_reg;
	logic [STAGES-1:0] chain_next;

	initial begin
		if (STAGES < 2) begin
			$error("pin_sync needs at least two stages");
		end
	end

	always_comb begin
		chain_next = {chain_reg[STAGES-2:0], pinIn};
	end

	// The chain keeps sampling through reset, so the mode levels held by
	// the board are already settled at its end when reset is released.
	// A reset chain would hand the idle level to the mode latch instead.
	// The rst port stays so that every stage is hooked up the same way.
	always_ff @(posedge clk) begin
		chain_reg <= chain_next;
	end

	assign pinSync = chain_reg[STAGES-1];
endmodule

// ---- design/boot_mode_latch_irq_pins.sv ----
// Mode latch, interrupt requests and port bits of the mode pins.
//
// Summary of operation
// [R1] Every active-low mode/interrupt pin is synchronised to clk before use.
// [R2] Four mode pins are captured into the operating mode register at reset release.
// [R3] After reset release the pins serve as interrupt requests, not mode selects.
// [R4] Each request is level or falling-edge sensitive, and individually maskable.
// [R5] Each pin may be a port bit: input, output or disconnected.
// [R6] In stop standby a low first pin raises the wake request.
// [R7] Board logic holds mode levels steady throughout hardware reset.
// [R8] Edge requests latch a pending flag on high-to-low until acknowledged.
//
// Only pins A to C serve as interrupts and port bits; pin D selects the
// mode alone. The operating mode register holds the raw pin levels, so a
// pin held low during reset reads as a zero bit.
// Requests and port inputs lag their pin by two synchroniser stages and
// one output register, three clock edges in all. Software that polls the
// port input right after changing a pin must allow for that delay.
// All outputs come from registers, so the core may sample them freely.
`timescale 1ns/1ns
`include "mode_irq_consts.svh"
module boot_mode_latch_irq_pins #(
	parameter int N_IRQ = `IRQ_PIN_COUNT
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// Pins, all active low
	input  wire logic                         modeSelAIrqAPinN,
	input  wire logic                         modeSelBIrqBPinN,
	input  wire logic                         modeSelCIrqCPinN,
	input  wire logic                         modeSelDPinN,
	// Pin drivers for port output use
	output logic [N_IRQ-1:0]                  portPinOut,
	output logic [N_IRQ-1:0]                  portPinOe,
	// Interrupt and port configuration
	input  wire mode_irq_pkg::irq_ctrl_type [N_IRQ-1:0] irqCtrl,
	input  wire logic [N_IRQ-1:0]             portSel,
	input  wire mode_irq_pkg::port_dir_type [N_IRQ-1:0] portDir,
	input  wire logic [N_IRQ-1:0]             portDataOut,
	input  wire logic                         stopStandby,
	// Status
	output logic [3:0]                        operatingModeRegister,
	output logic [N_IRQ-1:0]                  irqRequest,
	output logic [N_IRQ-1:0]                  irqPending,
	output logic [N_IRQ-1:0]                  portDataIn,
	output logic                              wakeRequest,
	output logic                              runPhase
);
	logic [3:0]        pinRaw;
	logic [3:0]        pinSync;
	logic [N_IRQ-1:0]  prev_reg;
	logic [N_IRQ-1:0]  prev_next;
	logic [N_IRQ-1:0]  pend_reg;
	logic [N_IRQ-1:0]  pend_next;
	logic [N_IRQ-1:0]  req_reg;
	logic [N_IRQ-1:0]  req_next;
	logic [N_IRQ-1:0]  din_reg;
	logic [N_IRQ-1:0]  din_next;
	logic [N_IRQ-1:0]  pout_reg;
	logic [N_IRQ-1:0]  pout_next;
	logic [N_IRQ-1:0]  poe_reg;
	logic [N_IRQ-1:0]  poe_next;
	logic [3:0]        omr_reg;
	logic [3:0]        omr_next;
	logic              wake_reg;
	logic              wake_next;
	logic              run_reg;
	logic              run_next;
	mode_irq_pkg::phase_type phase_reg;
	mode_irq_pkg::phase_type phase_next;

	initial begin
		if (N_IRQ < 1 || N_IRQ > 3) begin
			$error("N_IRQ must be 1 to 3");
		end
	end

	assign pinRaw = {modeSelDPinN, modeSelCIrqCPinN,
		modeSelBIrqBPinN, modeSelAIrqAPinN};

	// Every pin passes a synchroniser before any use.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gSync
			pin_sync #(.STAGES(`SYNC_STAGES)) uSync ( // [R1]
				.clk     (clk),
				.rst     (rst),
				.pinIn   (pinRaw[g]),
				.pinSync (pinSync[g])
			);
		end
	endgenerate

	// Phase and mode latch: the first edge after release takes the
	// synchronised pins, which carry the levels that the board held through
	// reset. The synchronisers run during reset for exactly this reason.
	// After that edge the register never changes until the next reset, so
	// later pin activity, which is interrupt traffic, cannot disturb it.
	always_comb begin
		phase_next = phase_reg;
		omr_next   = omr_reg;
		run_next   = 1'b0;
		case (phase_reg)
			mode_irq_pkg::PHASE_RESET: begin
				omr_next   = pinSync; // [R2] [R7]
				phase_next = mode_irq_pkg::PHASE_RUN; // [R3]
			end
			mode_irq_pkg::PHASE_RUN: begin
				phase_next = mode_irq_pkg::PHASE_RUN;
			end
			default: begin
				phase_next = mode_irq_pkg::PHASE_RESET;
			end
		endcase
		// The run flag is a register of its own so that the output does
		// not decode the state variable combinationally.
		run_next = (phase_next == mode_irq_pkg::PHASE_RUN);
	end

	// Interrupts, port bits and wake-up.
	// The previous sample follows the pins in every phase. Were it frozen
	// at its reset value, a pin held low through reset would look like a
	// falling edge on the first run cycle and raise a false request.
	// The port input reads zero unless the bit is an input port, so stale
	// input data never lingers after a change of direction.
	always_comb begin
		prev_next = pinSync[N_IRQ-1:0];
		pend_next = pend_reg;
		req_next  = '0;
		din_next  = '0;
		pout_next = pout_reg;
		poe_next  = '0;
		wake_next = 1'b0;
		if (phase_reg == mode_irq_pkg::PHASE_RUN) begin
			for (int i = 0; i < N_IRQ; i++) begin
				if (portSel[i]) begin
					// A port bit takes no part in interrupts.
					pend_next[i] = 1'b0; // [R5]
					case (portDir[i])
						mode_irq_pkg::PORT_INPUT: begin
							din_next[i] = pinSync[i]; // [R5]
						end
						mode_irq_pkg::PORT_OUTPUT: begin
							pout_next[i] = portDataOut[i]; // [R5]
							poe_next[i]  = 1'b1;
						end
						default: begin
							din_next[i] = 1'b0; // [R5]
						end
					endcase
				end else if (irqCtrl[i].edgeMode) begin
					// Set wins over a same-cycle acknowledge.
					if (prev_reg[i] && !pinSync[i]) begin
						pend_next[i] = 1'b1; // [R8]
					end else if (irqCtrl[i].ack) begin
						pend_next[i] = 1'b0; // [R8]
					end
					req_next[i] = pend_next[i] && irqCtrl[i].enable; // [R4]
				end else begin
					pend_next[i] = 1'b0;
					req_next[i]  = !pinSync[i] && irqCtrl[i].enable; // [R4]
				end
			end
			wake_next = stopStandby
				&& !pinSync[`WAKE_PIN_INDEX]; // [R6]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_reg <= mode_irq_pkg::PHASE_RESET;
			omr_reg   <= `OMR_RESET_VALUE;
			prev_reg  <= '1;
			pend_reg  <= '0;
			req_reg   <= '0;
			din_reg   <= '0;
			pout_reg  <= '0;
			poe_reg   <= '0;
			wake_reg  <= 1'b0;
			run_reg   <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			omr_reg   <= omr_next;
			prev_reg  <= prev_next;
			pend_reg  <= pend_next;
			req_reg   <= req_next;
			din_reg   <= din_next;
			pout_reg  <= pout_next;
			poe_reg   <= poe_next;
			wake_reg  <= wake_next;
			run_reg   <= run_next;
		end
	end

	// Output drivers. Each output is a register above; nothing here adds
	// logic between a flip-flop and a pin of the block.

	assign operatingModeRegister = omr_reg;
	assign irqRequest            = req_reg;
	assign irqPending            = pend_reg;
	assign portDataIn            = din_reg;
	assign portPinOut            = pout_reg;
	assign portPinOe             = poe_reg;
	assign wakeRequest           = wake_reg;
	assign runPhase              = run_reg;
endmodule

// ---- verif/board_pins.sv ----
// Board side model that holds the mode pin levels.
`timescale 1ns/1ns
module board_pins (
	input  wire logic       clk,
	input  wire logic [3:0] want,
	input  wire logic [2:0] oe,
	input  wire logic [2:0] drv,
	output logic      [3:0] pinN
);
	logic [3:0] held;
	// Levels move only after a falling edge and then stay put.
	always @(negedge clk) held <= want;
	assign pinN = {held[3], (oe & drv) | (~oe & held[2:0])};
endmodule

// ---- verif/mode_pins_chk.sv ----
// Assertions on the ports of the mode and interrupt pin block.
`timescale 1ns/1ns
module mode_pins_chk #(
	parameter int N_IRQ = 3
) (
	input wire logic                                   clk,
	input wire logic                                   rst,
	input wire logic                                   modeSelAIrqAPinN,
	input wire mode_irq_pkg::irq_ctrl_type [N_IRQ-1:0] irqCtrl,
	input wire logic [N_IRQ-1:0]                       portSel,
	input wire mode_irq_pkg::port_dir_type [N_IRQ-1:0] portDir,
	input wire logic [N_IRQ-1:0]                       portDataOut,
	input wire logic                                   stopStandby,
	input wire logic [3:0]                     operatingModeRegister,
	input wire logic [N_IRQ-1:0]                       irqRequest,
	input wire logic [N_IRQ-1:0]                       irqPending,
	input wire logic [N_IRQ-1:0]                       portPinOut,
	input wire logic [N_IRQ-1:0]                       portPinOe,
	input wire logic                                   wakeRequest,
	input wire logic                                   runPhase
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence pinAHigh;
		modeSelAIrqAPinN [*4];
	endsequence
	sync_delay_a: assert property (
		$fell(modeSelAIrqAPinN) && !irqPending[0] |=> !irqPending[0])
		else $error("pin bypassed sync");
	mode_hold_a: assert property (
		runPhase && $past(runPhase) |-> $stable(operatingModeRegister))
		else $error("mode moved after release");
	edge_set_a: assert property (
		$fell(modeSelAIrqAPinN) && runPhase && !portSel[0]
		&& irqCtrl[0].edgeMode
		|-> ##[2:3] irqPending[0]) else $error("edge not pending");
	mask_req_a: assert property (
		!irqCtrl[0].enable ##1 !irqCtrl[0].enable |-> !irqRequest[0])
		else $error("masked request seen");
	ack_clear_a: assert property (
		pinAHigh ##0 irqCtrl[0].ack |=> !irqPending[0])
		else $error("ack ignored");
	stop_wake_a: assert property (
		(stopStandby && !modeSelAIrqAPinN) [*4] |=> wakeRequest)
		else $error("no wake");
	port_out_a: assert property (
		portSel[1] && portDir[1] == mode_irq_pkg::PORT_OUTPUT
		|=> portPinOe[1] && portPinOut[1] == $past(portDataOut[1]))
		else $error("port output wrong");
endmodule
bind boot_mode_latch_irq_pins mode_pins_chk #(.N_IRQ(N_IRQ)) chk (.*);

// ---- verif/tb_top.sv ----
// Self-checking bench for the mode and interrupt pin block.
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, rst = 1, stopStandby = 0, wake, run;
	logic [3:0] want = 4'hf, mode, pinN, operating_mode_register;
	logic [2:0] portSel = 0, portDataOut = 0, oe, drv, req, pend, din;
	mode_irq_pkg::irq_ctrl_type [2:0] irqCtrl = '0;
	mode_irq_pkg::port_dir_type [2:0] portDir;
	int numErrors = 0, checks = 0, cyc = 0;
	logic [3:0] expQ[$];
	boot_mode_latch_irq_pins uut (.clk(clk), .rst(rst),
		.modeSelAIrqAPinN(pinN[0]), .modeSelBIrqBPinN(pinN[1]),
		.modeSelCIrqCPinN(pinN[2]), .modeSelDPinN(pinN[3]),
		.portPinOut(drv), .portPinOe(oe), .irqCtrl(irqCtrl),
		.portSel(portSel), .portDir(portDir), .portDataOut(portDataOut),
		.stopStandby(stopStandby), .operatingModeRegister(operating_mode_register),
		.irqRequest(req), .irqPending(pend), .portDataIn(din),
		.wakeRequest(wake), .runPhase(run));
	board_pins partner (.clk(clk), .want(want), .oe(oe), .drv(drv),
		.pinN(pinN));
	initial forever #10 clk = ~clk;
	task check(input string what, input logic [3:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			numErrors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		if (numErrors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 1000) begin
		numErrors++;
		complete_run;
	end
	// Every pending change must have been announced by the driver.
	always @(pend) if (!rst) begin
		#1;
		check("pending", 4'(pend), expQ.size() > 0 ? expQ.pop_front() : 4'hx);
	end
	task pulse(input int i, input logic [2:0] ctl);
		irqCtrl[i] <= ctl;
		want[i] <= 0;
		expQ.push_back(4'(1 << i));
		repeat (6) @(negedge clk);
		check("request", 4'(req[i]), 4'(ctl[2]));
		check("wake", 4'(wake), 4'(i == 0));
		want[i] <= 1;
		repeat (6) @(negedge clk);
		irqCtrl[i].ack <= 1;
		expQ.push_back(4'h0);
		@(negedge clk);
		irqCtrl[i].ack <= 0;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		void'($urandom(32'h6159_f790));
		foreach (portDir[i]) portDir[i] = mode_irq_pkg::PORT_DISCONNECTED;
		mode = 4'($urandom);
		want = mode;
		repeat (6) @(negedge clk);
		check("run", 4'(run), 4'h0);
		rst = 0;
		repeat (4) @(negedge clk);
		check("mode", operating_mode_register, mode);
		check("run", 4'(run), 4'h1);
		want <= 4'hf;
		stopStandby <= 1;
		repeat (6) @(negedge clk);
		check("mode", operating_mode_register, mode);
		pulse(0, 3'h6);
		pulse(1, 3'h2);
		portSel <= 3'h2;
		for (int k = 0; k < 3; k++) begin
			portDir[1] <= mode_irq_pkg::port_dir_type'(k);
			portDataOut <= 3'($urandom);
			want[1] <= 1'($urandom);
			repeat (5) @(negedge clk);
			check("oe", 4'(oe[1]), 4'(k == 2));
			check("port in", 4'(din[1]), 4'(k == 1 && want[1]));
			if (k == 2) check("port out", 4'(drv[1]), 4'(portDataOut[1]));
		end
		complete_run;
	end
endmodule
